// File: alarm_consts.svh
// Purpose: named constants for the converter alarm monitor
// Assumes: byte-wide registers on the serial control port
// Notes:   included by the design files
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH
`define ADDR_SUMMARY    15'h02C0
`define ADDR_STATUS     15'h02C1
`define ADDR_MASK       15'h02C2
`define ADDR_LANE_LO    15'h02C4
`define ADDR_LANE_HI    15'h02C5
`define BIT_FIFO        5
`define BIT_PLL         4
`define BIT_LINK        3
`define BIT_REALIGN     2
`define BIT_NCO         1
`define BIT_CLK         0
`define NUM_FLAGS       6
`define STATUS_RESET    6'h3F
`define MASK_RESET      6'h3F
`define LANE_RESET      16'hFFFF
`define FLAG_PAD        2'h0
`define SUMMARY_PAD     7'h00
`define READ_ZERO       8'h00
`endif

// File: alarm_pkg.sv
// Purpose: shared types for the converter alarm monitor
// Assumes: six alarm flags
// Notes:   constants live in alarm_consts.svh
package alarm_pkg;
   typedef logic [5:0]  flags_t;
   typedef logic [7:0]  byte_t;
   typedef logic [14:0] addr_t;
   typedef enum logic [1:0] {
      ENC_8B10B  = 2'b00,
      ENC_64B66B = 2'b01
   } encoding_t;
endpackage

// File: alarm_if.sv
// Purpose: carries alarm causes from the cause logic to the register core
// Assumes: single clock domain
// Notes:   set terms are one cycle wide or levels
`timescale 1ns/1ps
interface alarm_if;
   import alarm_pkg::*;
   flags_t setTerms;
   modport src  (output setTerms);
   modport sink (input setTerms);
endinterface

// File: alarm_causes.sv
// Purpose: turns raw device conditions into alarm set terms
// Assumes: all inputs synchronous to mclk
// Notes:   combinational only
`timescale 1ns/1ps
`include "alarm_consts.svh"
module alarm_causes #(
   parameter int LANES = 16
) (
   // Conditions
   input  wire logic               linkEnable,
   input  wire alarm_pkg::encoding_t encMode,
   input  wire logic [LANES-1:0]   laneFifoErr,
   input  wire logic               pllLocked,
   input  wire logic               linkInData,
   input  wire logic               linkRealign,
   input  wire logic               sysrefRealign,
   input  wire logic               ncoSynced,
   input  wire logic               ncoPhaseDiff,
   input  wire logic               dividerMismatch,
   // Set terms
   alarm_if.src                    causes
);
   import alarm_pkg::*;
   logic linkSet;
   always_comb begin
      linkSet = 1'b0;
      if (encMode == ENC_8B10B) begin
         linkSet = linkEnable && !linkInData;
      end else begin
         // Startup seen as link enabled but not yet in data state
         linkSet = linkEnable && (linkRealign || !linkInData);
      end
   end
   assign causes.setTerms[`BIT_FIFO]    = |laneFifoErr;
   assign causes.setTerms[`BIT_PLL]     = !pllLocked;
   assign causes.setTerms[`BIT_LINK]    = linkSet;
   assign causes.setTerms[`BIT_REALIGN] = sysrefRealign;
   assign causes.setTerms[`BIT_NCO]     = !linkEnable || ncoSynced || ncoPhaseDiff;
   assign causes.setTerms[`BIT_CLK]     = dividerMismatch;
endmodule

// File: converter_alarm_monitor.sv
// Purpose: sticky alarm flags, mask, summary bit and status pin routing
// Assumes: host serial port decoded to byte read/write strobes; inputs sync to mclk
// Notes:   flags other than the clock flag are meaningless while the link is off
`timescale 1ns/1ps
`include "alarm_consts.svh"
// How it works
// - summary set when any unmasked flag set
// - summary drives status pin when selected
// - FIFO flag bit5 on lane overflow/underflow
// - PLL flag bit4 while unlocked
// - 8b10b: link flag when outside data state
// - 64b66b: link flag on startup, realign
// - realign flag bit2 on SYSREF realignment
// - NCO flag: link off, synced, mismatch
// - clock flag bit0 on divider mismatch
// - flags clear only by writing one
// - reset sets six flags, reserved zero
// - non-clock flags undefined while link off
// - mask bit per flag, resets to ones
// - per-lane FIFO field, write-one clear
module converter_alarm_monitor #(
   parameter int LANES = 16
) (
   // Clock and reset
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   input  wire logic                 clkEn,
   // Register port
   input  wire alarm_pkg::addr_t     regAddr,
   input  wire alarm_pkg::byte_t     regWdata,
   input  wire logic                 regWrite,
   input  wire logic                 regRead,
   output alarm_pkg::byte_t          regRdata_ff,
   // Device conditions
   input  wire logic                 linkEnable,
   input  wire alarm_pkg::encoding_t encMode,
   input  wire logic [LANES-1:0]     laneFifoErr,
   input  wire logic                 pllLocked,
   input  wire logic                 linkInData,
   input  wire logic                 linkRealign,
   input  wire logic                 sysrefRealign,
   input  wire logic                 ncoSynced,
   input  wire logic                 ncoPhaseDiff,
   input  wire logic                 dividerMismatch,
   // Status pin
   input  wire logic                 statusPinSel,
   input  wire logic                 calStatus,
   output logic                      statusPin_ff,
   output logic                      summary_ff
);
   import alarm_pkg::*;

   alarm_if causesBus();

   alarm_causes #(.LANES(LANES)) uCauses (
      .linkEnable      (linkEnable),
      .encMode         (encMode),
      .laneFifoErr     (laneFifoErr),
      .pllLocked       (pllLocked),
      .linkInData      (linkInData),
      .linkRealign     (linkRealign),
      .sysrefRealign   (sysrefRealign),
      .ncoSynced       (ncoSynced),
      .ncoPhaseDiff    (ncoPhaseDiff),
      .dividerMismatch (dividerMismatch),
      .causes          (causesBus.src)
   );

   flags_t           flags_ff,   nxt_flags;
   flags_t           mask_ff,    nxt_mask;
   logic [LANES-1:0] lanes_ff,   nxt_lanes;
   byte_t            nxt_rdata;
   logic             nxt_summary;
   logic             nxt_statusPin;
   logic             wrStatus, wrMask, wrLaneLo, wrLaneHi;
   flags_t           clrFlags;
   logic [LANES-1:0] clrLanes;

   assign wrStatus = regWrite && (regAddr == `ADDR_STATUS);
   assign wrMask   = regWrite && (regAddr == `ADDR_MASK);
   assign wrLaneLo = regWrite && (regAddr == `ADDR_LANE_LO);
   assign wrLaneHi = regWrite && (regAddr == `ADDR_LANE_HI);

   // Reserved bits 7:6 are dropped here, so writes to them do nothing
   assign clrFlags = wrStatus ? regWdata[`NUM_FLAGS-1:0] : '0;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gLane
         // Lanes 8 and above sit in the high byte
         if (g < 8) begin : gLo
            assign clrLanes[g] = (wrLaneLo && regWdata[g]) ||
                                 (wrStatus && regWdata[`BIT_FIFO]);
         end else begin : gHi
            assign clrLanes[g] = (wrLaneHi && regWdata[g-8]) ||
                                 (wrStatus && regWdata[`BIT_FIFO]);
         end
      end
   endgenerate

   always_comb begin
      nxt_flags     = (flags_ff & ~clrFlags) | causesBus.setTerms;
      nxt_lanes     = (lanes_ff & ~clrLanes) | laneFifoErr;
      nxt_mask      = wrMask ? regWdata[`NUM_FLAGS-1:0] : mask_ff;
      // Built from next state so the bit moves in the same cycle as its flags
      nxt_summary   = |(nxt_flags & ~nxt_mask);
      nxt_statusPin = statusPinSel ? nxt_summary : calStatus;
      nxt_rdata     = regRdata_ff;
      if (regRead) begin
         unique case (regAddr)
            `ADDR_SUMMARY: nxt_rdata = {`SUMMARY_PAD, summary_ff};
            `ADDR_STATUS:  nxt_rdata = {`FLAG_PAD, flags_ff};
            `ADDR_MASK:    nxt_rdata = {`FLAG_PAD, mask_ff};
            `ADDR_LANE_LO: nxt_rdata = lanes_ff[7:0];
            `ADDR_LANE_HI: nxt_rdata = lanes_ff[LANES-1:8];
            default:       nxt_rdata = `READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags_ff     <= `STATUS_RESET;
         mask_ff      <= `MASK_RESET;
         lanes_ff     <= `LANE_RESET;
         summary_ff   <= 1'b0;
         statusPin_ff <= 1'b0;
         regRdata_ff  <= `READ_ZERO;
      end else if (clkEn) begin
         flags_ff     <= nxt_flags;
         mask_ff      <= nxt_mask;
         lanes_ff     <= nxt_lanes;
         summary_ff   <= nxt_summary;
         statusPin_ff <= nxt_statusPin;
         regRdata_ff  <= nxt_rdata;
      end
   end

   // Checks
   sequence s_clearWrite(int b);
      wrStatus && regWdata[b] && clkEn;
   endsequence

   property p_summary;
      @(posedge mclk) disable iff (!rstn)
      clkEn |=> (summary_ff == |(flags_ff & ~mask_ff));
   endproperty
   a_summary: assert property (p_summary) else $error("summary mismatch");

   property p_pin;
      @(posedge mclk) disable iff (!rstn)
      clkEn && statusPinSel |=> (statusPin_ff == summary_ff);
   endproperty
   a_pin: assert property (p_pin) else $error("status pin mismatch");

   property p_fifo;
      @(posedge mclk) disable iff (!rstn)
      clkEn && (|laneFifoErr) |=> flags_ff[`BIT_FIFO];
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo flag not set");

   property p_pll;
      @(posedge mclk) disable iff (!rstn)
      clkEn && !pllLocked |=> flags_ff[`BIT_PLL];
   endproperty
   a_pll: assert property (p_pll) else $error("pll flag not set");

   property p_link8;
      @(posedge mclk) disable iff (!rstn)
      clkEn && encMode == ENC_8B10B && linkEnable && !linkInData |=> flags_ff[`BIT_LINK];
   endproperty
   a_link8: assert property (p_link8) else $error("link flag not set");

   property p_realign;
      @(posedge mclk) disable iff (!rstn)
      clkEn && sysrefRealign |=> flags_ff[`BIT_REALIGN];
   endproperty
   a_realign: assert property (p_realign) else $error("realign flag not set");

   property p_nco;
      @(posedge mclk) disable iff (!rstn)
      clkEn && (ncoSynced || ncoPhaseDiff) |=> flags_ff[`BIT_NCO];
   endproperty
   a_nco: assert property (p_nco) else $error("nco flag not set");

   property p_clkClear;
      @(posedge mclk) disable iff (!rstn)
      s_clearWrite(`BIT_CLK) ##0 !dividerMismatch |=> !flags_ff[`BIT_CLK];
   endproperty
   a_clkClear: assert property (p_clkClear) else $error("clock flag not cleared");

   property p_sticky;
      @(posedge mclk) disable iff (!rstn)
      flags_ff[`BIT_CLK] && !(wrStatus && regWdata[`BIT_CLK]) |=> flags_ff[`BIT_CLK];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

   property p_maskWrite;
      @(posedge mclk) disable iff (!rstn)
      clkEn && wrMask |=> mask_ff == $past(regWdata[`NUM_FLAGS-1:0]);
   endproperty
   a_maskWrite: assert property (p_maskWrite) else $error("mask not written");

   property p_setWins;
      @(posedge mclk) disable iff (!rstn)
      s_clearWrite(`BIT_CLK) ##0 dividerMismatch |=> flags_ff[`BIT_CLK];
   endproperty
   a_setWins: assert property (p_setWins) else $error("clear beat set");

   property p_link64;
      @(posedge mclk) disable iff (!rstn)
      clkEn && encMode == ENC_64B66B && linkEnable && linkRealign |=> flags_ff[`BIT_LINK];
   endproperty
   a_link64: assert property (p_link64) else $error("link flag not set");

   property p_laneField;
      @(posedge mclk) disable iff (!rstn)
      clkEn |=> ((lanes_ff & $past(laneFifoErr)) == $past(laneFifoErr));
   endproperty
   a_laneField: assert property (p_laneField) else $error("lane bit not set");

   // The clock flag is checked while the link is off; the FIFO, PLL, realign and NCO checks also run then
   property p_clkLinkOff;
      @(posedge mclk) disable iff (!rstn)
      clkEn && !linkEnable && dividerMismatch |=> flags_ff[`BIT_CLK];
   endproperty
   a_clkLinkOff: assert property (p_clkLinkOff) else $error("clock flag lost");

   property p_rdPad;
      @(posedge mclk) disable iff (!rstn)
      clkEn && regRead && (regAddr == `ADDR_STATUS) |=>
      (regRdata_ff[$bits(byte_t)-1:`NUM_FLAGS] == `FLAG_PAD);
   endproperty
   a_rdPad: assert property (p_rdPad) else $error("reserved bits not zero");
endmodule

// File: host_model.sv
// Purpose: host on the serial control port, byte reads and writes
// Assumes: requests launched 1 ns after a rising edge of mclk
// Notes:   released write data shows the inverse of the last value
`timescale 1ns/1ps
module host_model (
   // Bus
   input  wire logic             mclk,
   output alarm_pkg::addr_t      regAddr,
   output alarm_pkg::byte_t      regWdata,
   output logic                  regWrite,
   output logic                  regRead,
   input  wire alarm_pkg::byte_t regRdata_ff
);
   import alarm_pkg::*;
   initial begin
      regAddr = '0;
      regWdata = '0;
      regWrite = 1'b0;
      regRead = 1'b0;
   end
   task automatic wr(input addr_t a, input byte_t d);
      @(posedge mclk) #1;
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge mclk) #1;
      regWrite = 1'b0;
      regWdata = ~d; // Stale data must not look valid
   endtask
   task automatic rd(input addr_t a, output byte_t d);
      @(posedge mclk) #1;
      regAddr = a;
      regRead = 1'b1;
      @(posedge mclk) #1;
      regRead = 1'b0;
      d = regRdata_ff;
   endtask
endmodule

// File: converter_alarm_monitor_tb.sv
// Purpose: self-checking bench for the alarm monitor
// Assumes: link enabled except in the link-off scenario, which checks only defined flags
// Notes:   each cause is raised, read back and cleared
`timescale 1ns/1ps
`include "alarm_consts.svh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module converter_alarm_monitor_tb;
   import alarm_pkg::*;
   logic        mclk = 1'b0;
   logic        rstn, linkEnable, pllLocked, linkInData, linkRealign, sysrefRealign;
   logic        ncoSynced, ncoPhaseDiff, dividerMismatch, statusPinSel, calStatus;
   logic        regWrite, regRead, statusPin_ff, summary_ff, clkEn;
   encoding_t   encMode;
   logic [15:0] laneFifoErr;
   addr_t       regAddr;
   byte_t       regWdata, regRdata_ff;
   int          errors = 0, nCompared = 0, cycles = 0;
   always #5 mclk = ~mclk;
   host_model host (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata_ff(regRdata_ff));
   converter_alarm_monitor #(.LANES(16)) DUT (.mclk(mclk), .rstn(rstn), .clkEn(clkEn),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata_ff(regRdata_ff), .linkEnable(linkEnable), .encMode(encMode),
      .laneFifoErr(laneFifoErr), .pllLocked(pllLocked), .linkInData(linkInData),
      .linkRealign(linkRealign), .sysrefRealign(sysrefRealign), .ncoSynced(ncoSynced),
      .ncoPhaseDiff(ncoPhaseDiff), .dividerMismatch(dividerMismatch),
      .statusPinSel(statusPinSel), .calStatus(calStatus), .statusPin_ff(statusPin_ff),
      .summary_ff(summary_ff));
   task end_sim;
      if (errors == 0 && nCompared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task step;
      @(posedge mclk) #1;
   endtask
   task chkReg(input addr_t a, input byte_t e);
      byte_t d;
      host.rd(a, d);
      `CHK(d, e)
   endtask
   task chkBits(input addr_t a, input byte_t m, input byte_t e);
      byte_t d;
      host.rd(a, d);
      `CHK(d & m, e)
   endtask
   task flagIs(input byte_t e);
      chkReg(`ADDR_STATUS, e);
      host.wr(`ADDR_STATUS, e);
      chkReg(`ADDR_STATUS, 8'h00);
   endtask
   task t_reset;
      chkReg(`ADDR_STATUS, 8'h3F);
      chkReg(`ADDR_MASK, 8'h3F);
      chkReg(`ADDR_LANE_HI, 8'hFF);
      chkReg(`ADDR_SUMMARY, 8'h00);
      chkReg(15'h02C3, 8'h00);
      host.wr(`ADDR_STATUS, 8'hC0);
      chkReg(`ADDR_STATUS, 8'h3F);
   endtask
   task t_clear;
      host.wr(`ADDR_STATUS, 8'hFF);
      chkReg(`ADDR_STATUS, 8'h00);
      chkReg(`ADDR_LANE_LO, 8'h00);
      chkReg(`ADDR_LANE_HI, 8'h00);
   endtask
   task t_causes;
      sysrefRealign = 1'b1; step; sysrefRealign = 1'b0;
      flagIs(8'h04);
      ncoSynced = 1'b1; step; ncoSynced = 1'b0;
      flagIs(8'h02);
      ncoPhaseDiff = 1'b1; step; ncoPhaseDiff = 1'b0;
      flagIs(8'h02);
      pllLocked = 1'b0; step; pllLocked = 1'b1;
      flagIs(8'h10);
      linkInData = 1'b0; step; linkInData = 1'b1;
      flagIs(8'h08);
      dividerMismatch = 1'b1; step; dividerMismatch = 1'b0;
      flagIs(8'h01);
      laneFifoErr = 16'h0201; step; laneFifoErr = 16'h0000;
      chkReg(`ADDR_LANE_HI, 8'h02);
      host.wr(`ADDR_LANE_LO, 8'h01);
      chkReg(`ADDR_LANE_LO, 8'h00);
      flagIs(8'h20);
      chkReg(`ADDR_LANE_HI, 8'h00);
      encMode = ENC_64B66B; linkRealign = 1'b1; step; linkRealign = 1'b0;
      flagIs(8'h08);
   endtask
   task t_summary;
      dividerMismatch = 1'b1;
      host.wr(`ADDR_STATUS, 8'h01);
      chkReg(`ADDR_STATUS, 8'h01);
      `CHK(summary_ff, 1'b0)
      host.wr(`ADDR_MASK, 8'h3E);
      step; step;
      `CHK(summary_ff, 1'b1)
      `CHK(statusPin_ff, 1'b0)
      statusPinSel = 1'b1; step; step;
      `CHK(statusPin_ff, 1'b1)
      host.wr(`ADDR_SUMMARY, 8'h00);
      chkReg(`ADDR_SUMMARY, 8'h01);
      dividerMismatch = 1'b0;
      host.wr(`ADDR_STATUS, 8'h01);
      step;
      `CHK(summary_ff, 1'b0)
      `CHK(statusPin_ff, 1'b0)
      statusPinSel = 1'b0;
      calStatus = 1'b1;
      step;
      `CHK(statusPin_ff, 1'b1)
      calStatus = 1'b0;
   endtask
   task t_freeze;
      clkEn = 1'b0;
      dividerMismatch = 1'b1;
      step;
      dividerMismatch = 1'b0;
      host.wr(`ADDR_MASK, 8'h00);
      clkEn = 1'b1;
      chkReg(`ADDR_MASK, 8'h3E);
      chkReg(`ADDR_STATUS, 8'h00);
   endtask
   task t_linkOff;
      linkEnable = 1'b0;
      dividerMismatch = 1'b1;
      step;
      dividerMismatch = 1'b0;
      chkBits(`ADDR_STATUS, 8'h01, 8'h01);
      host.wr(`ADDR_STATUS, 8'h01);
      chkBits(`ADDR_STATUS, 8'h01, 8'h00);
      linkEnable = 1'b1;
      chkBits(`ADDR_STATUS, 8'h02, 8'h02);
      host.wr(`ADDR_STATUS, 8'h3F);
      chkReg(`ADDR_STATUS, 8'h00);
   endtask
   task t_softReset;
      rstn = 1'b0;
      step;
      rstn = 1'b1;
      chkReg(`ADDR_STATUS, 8'h3F);
      chkReg(`ADDR_MASK, 8'h3F);
      chkReg(`ADDR_LANE_LO, 8'hFF);
      `CHK(summary_ff, 1'b0)
   endtask
   // Cut a hang short well beyond the roughly 140 cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         end_sim;
      end
   end
   initial begin
      {rstn, linkRealign, sysrefRealign, ncoSynced, ncoPhaseDiff} = '0;
      {dividerMismatch, statusPinSel, calStatus} = '0;
      clkEn = 1'b1;
      {linkEnable, pllLocked, linkInData} = 3'h7;
      encMode = ENC_8B10B;
      laneFifoErr = 16'h0000;
      repeat (10) @(posedge mclk);
      #1 rstn = 1'b1;
      t_reset;
      t_clear;
      t_causes;
      t_summary;
      t_freeze;
      t_linkOff;
      t_softReset;
      end_sim;
   end
endmodule
